// >>> rtl/edge_sync.sv
/*
 * Two-flop synchroniser with falling-edge detector for one pin input.
 * Assumes mclk and an asynchronous active-low reset; pin may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none

module edge_sync
    import wdt_pkg::*;
(
    input wire logic mclk,               // system clock
    input wire logic reset_n,            // asynchronous reset, active low
    edge_sync_if.producer port           // raw in, level and fall out
);
    logic [1:0] sync_reg;
    logic [1:0] sync_next;
    logic last_reg;
    logic last_next;

    // stage 0 is read only by stage 1; edge logic looks at stage 1 and later
    always_comb
    begin
        sync_next = {sync_reg[0], port.raw};
        last_next = sync_reg[1];
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_reg <= SYNC_RESET;
            last_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign port.level = sync_reg[1];
    assign port.fall = last_reg & ~sync_reg[1];

endmodule

`default_nettype wire

// >>> rtl/edge_sync_if.sv
/*
 * Carrier between the supervisor and its input synchronisers: raw pin level
 * in, synchronised level and falling-edge pulse out.
 * Assumes one clock domain, mclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface edge_sync_if;
    logic raw;    // asynchronous pin level
    logic level;  // level after two flip-flops
    logic fall;   // one-cycle pulse on a synchronised falling edge

    modport producer (input raw, output level, output fall);
    modport consumer (output raw, input level, input fall);
endinterface

`default_nettype wire

// >>> rtl/sleep_poll_watchdog_reset.sv
/*
 * Sleep-poll watchdog and reset supervisor: square-wave poll output, kick
 * monitoring on the watchdog input, active-low reset on a missed kick or a
 * supply fault, all timings scaled from one value.
 * Assumes a free-running 50 MHz mclk, asynchronous pin inputs, and a host
 * that answers each poll rise with a falling edge on the watchdog input.
 * Kicks are honoured only while poll cycles run; a kick during the reset
 * pulse or the lead is dropped.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - poll output runs as a 50% square wave while poll cycles run, period from scale.
// - first kick falling edge in a cycle drives poll low until next cycle.
// - later kick edges in the same cycle change nothing.
// - a whole cycle without kick edge gives a reset pulse at cycle end.
// - poll output is held low whenever reset is asserted.
// - after reset release the poll cycle restarts from its beginning.
// - at power up reset stays asserted until supply good first appears.
// - supply fault asserts reset; release after supply returns plus reset delay.
// - poll period, reset delay and lead delay scale 4.17, 5.21, 2.08.
module sleep_poll_watchdog_reset
    import wdt_pkg::*;
#(
    parameter int unsigned scale_ohm = wdt_pkg::SCALE_OHM_DEFAULT,  // timing scale value
    parameter int unsigned poll_cycles = wdt_pkg::scaled_cycles(
        wdt_pkg::POLL_PERIOD_FS_PER_OHM, scale_ohm),               // poll period
    parameter int unsigned reset_cycles = wdt_pkg::scaled_cycles(
        wdt_pkg::RESET_DELAY_FS_PER_OHM, scale_ohm),               // reset delay
    parameter int unsigned lead_cycles = wdt_pkg::scaled_cycles(
        wdt_pkg::LEAD_DELAY_FS_PER_OHM, scale_ohm)                 // release to poll rise
)
(
    input wire logic mclk,               // 50 MHz system clock
    input wire logic reset_n,            // asynchronous reset, active low
    input wire logic watchdog_kick_in,   // kick from host, falling edge counts
    input wire logic supply_good_in,     // supply within regulation
    output logic poll_out,               // square-wave poll to the host
    output logic reset_out_n             // reset to the host, active low
);
    import wdt_pkg::*;

    // terminal values of the shared counter; each timing ends on its last count,
    // so a timing of n cycles keeps its state for exactly n edges
    // an odd poll period puts the extra cycle into the low half
    localparam logic [31:0] POLL_LAST = 32'(poll_cycles - 1);
    localparam logic [31:0] POLL_HALF = 32'(poll_cycles / 2);
    localparam logic [31:0] RESET_LAST = 32'(reset_cycles - 1);
    localparam logic [31:0] LEAD_LAST = 32'(lead_cycles - 1);

    // one carrier per pin; the kick path uses the edge pulse, the supply path the level
    edge_sync_if kick_if ();
    edge_sync_if supply_if ();

    assign kick_if.raw = watchdog_kick_in;
    assign supply_if.raw = supply_good_in;

    // kick path: two flops then an edge register; the fall pulse appears two edges after the pin
    edge_sync kick_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .port(kick_if.producer)
    );

    // supply path: the same cell, only the settled level is read
    edge_sync supply_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .port(supply_if.producer)
    );

    // supervisor group: state, shared counter and the kick flag
    sup_state_t state_reg;
    sup_state_t state_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic kicked_reg;
    logic kicked_next;
    // output group: both outputs come straight from flip-flops
    logic poll_reg;
    logic poll_next;
    logic rst_n_reg;
    logic rst_n_next;
    // synchronised views of the two pins
    logic supply_ok;
    logic kick_fall;

    // the settled supply level and the kick edge are all the sequencer reads
    assign supply_ok = supply_if.level;
    assign kick_fall = kick_if.fall;

    // supervisor sequencing; one shared counter serves all three timings,
    // which is safe because only one timing runs in any state
    // a fall pulse is one cycle wide, so one kick can never be counted twice
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg + 32'h0000_0001;
        kicked_next = kicked_reg;
        unique case (state_reg)
            ST_HOLD:
            begin
                count_next = COUNT_RESET;
                kicked_next = 1'b0;
                // nothing counts while the supply is bad; the reset delay
                // starts only once the synchronised level has come back
                // wait for supply
                if (supply_ok)
                begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                // the same count times the missed-kick pulse and the fault return
                // reset delay count
                if (count_reg >= RESET_LAST)
                begin
                    state_next = ST_LEAD;
                    count_next = COUNT_RESET;
                end
            end
            ST_LEAD:
            begin
                // the poll cycle always starts at count zero, never where it was cut
                // restart from lead
                if (count_reg >= LEAD_LAST)
                begin
                    state_next = ST_RUN;
                    count_next = COUNT_RESET;
                    kicked_next = 1'b0;
                end
            end
            ST_RUN:
            begin
                // the flag, not the pin, holds poll low, so a kick pin that
                // returns high early cannot lift the poll output again
                // first kick latches
                if (kick_fall)
                begin
                    kicked_next = 1'b1;
                end
                if (count_reg >= POLL_LAST)
                begin
                    count_next = COUNT_RESET;
                    kicked_next = 1'b0;
                    // a kick on the last count still saves this cycle; the flag
                    // is cleared with the new cycle, so it never carries over
                    // missed kick reset
                    if (!kicked_reg && !kick_fall)
                    begin
                        state_next = ST_DELAY;
                    end
                end
            end
        endcase
        // a fault during the reset pulse or the lead restarts the whole sequence
        // supply fault overrides
        if (!supply_ok)
        begin
            state_next = ST_HOLD;
            count_next = COUNT_RESET;
            kicked_next = 1'b0;
        end
    end

    // outputs registered from the next state so they carry no glitches
    // trade-off: decoding the next state costs a wider compare but saves an
    // edge of latency; poll still lags the kick pin by three edges
    always_comb
    begin
        rst_n_next = (state_next == ST_LEAD) || (state_next == ST_RUN);
        poll_next = (state_next == ST_RUN) && (count_next < POLL_HALF) && !kicked_next;
    end

    // supervisor group registers; reset lands in the supply-bad state, so
    // every power-up runs the full reset delay after supply good
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_HOLD;
            count_reg <= COUNT_RESET;
            kicked_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            kicked_reg <= kicked_next;
        end
    end

    // output group registers; both reset low so the host is held from the
    // first edge and never sees a poll pulse while reset is asserted
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            poll_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            poll_reg <= poll_next;
            rst_n_reg <= rst_n_next;
        end
    end

    // pins follow the registers directly, no logic between flop and pin
    assign poll_out = poll_reg;
    assign reset_out_n = rst_n_reg;

endmodule

`default_nettype wire

// >>> rtl/wdt_pkg.sv
/*
 * Shared constants for the sleep-poll watchdog: clock rate, timing
 * coefficients, default scaling value, reset values and the state encoding.
 * Assumes a 50 MHz free-running system clock.
 */
package wdt_pkg;

    // system clock period in femtoseconds (20 ns at 50 MHz)
    localparam longint unsigned CLK_PERIOD_FS = 64'd20_000_000;

    // default scaling value, in ohms of the timing resistor
    localparam int unsigned SCALE_OHM_DEFAULT = 32'd60000;

    // time per ohm of scaling value, in femtoseconds (4.17, 5.21, 2.08 x 1e-7..1e-8 s)
    localparam longint unsigned POLL_PERIOD_FS_PER_OHM = 64'd417_000_000;
    localparam longint unsigned RESET_DELAY_FS_PER_OHM = 64'd52_100_000;
    localparam longint unsigned LEAD_DELAY_FS_PER_OHM = 64'd208_000_000;

    // cycles for a time that scales with the parameter; never below one cycle
    function automatic int unsigned scaled_cycles(input longint unsigned fs_per_ohm,
                                                  input int unsigned ohm);
        longint unsigned c;
        c = (fs_per_ohm * longint'(ohm)) / CLK_PERIOD_FS;
        if (c < 64'd1)
        begin
            c = 64'd1;
        end
        return int'(c[31:0]);
    endfunction

    localparam int unsigned POLL_CYCLES_DEFAULT =
        scaled_cycles(POLL_PERIOD_FS_PER_OHM, SCALE_OHM_DEFAULT);
    localparam int unsigned RESET_CYCLES_DEFAULT =
        scaled_cycles(RESET_DELAY_FS_PER_OHM, SCALE_OHM_DEFAULT);
    localparam int unsigned LEAD_CYCLES_DEFAULT =
        scaled_cycles(LEAD_DELAY_FS_PER_OHM, SCALE_OHM_DEFAULT);

    // reset values
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // supervisor states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,   // supply bad: reset held
        ST_DELAY = 2'b01,  // reset held for the reset delay
        ST_LEAD = 2'b10,   // reset released, waiting for first poll rise
        ST_RUN = 2'b11     // poll cycles running
    } sup_state_t;

endpackage

// >>> verif/sleep_poll_watchdog_reset_properties.sv
/* timing checker for the poll watchdog, bound to its top module.
   assumes kicks never fall in the last cycles of a poll cycle. */
`timescale 1ns/1ps
`default_nettype none
module sleep_poll_watchdog_reset_properties #(
    parameter int unsigned poll_cycles = 1200, // poll period
    parameter int unsigned reset_cycles = 150, // reset delay
    parameter int unsigned lead_cycles = 600 // release to poll rise
)
(
    input wire logic mclk, // clock
    input wire logic reset_n, // reset, active low
    input wire logic watchdog_kick_in, // host kick
    input wire logic supply_good_in, // supply good
    input wire logic poll_out, // poll wave
    input wire logic reset_out_n // reset to host, active low
);
    localparam int P = poll_cycles;
    localparam int H = poll_cycles / 2;
    localparam int LD_LO = lead_cycles - 1;
    localparam int LD_HI = lead_cycles + 3;
    localparam int RL_LO = reset_cycles + 2;
    localparam int RL_HI = reset_cycles + 8;
    localparam int PW_LO = reset_cycles - 1;
    localparam int PW_HI = reset_cycles + 3;
    logic prev_poll, prev_kick, armed, kicked, rise;
    logic [31:0] since_rise;
    assign rise = poll_out && !prev_poll;
    // cycle position since the last poll rise; armed only after a full release
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_poll <= 1'b0;
            prev_kick <= 1'b1;
            armed <= 1'b0;
            kicked <= 1'b0;
            since_rise <= 32'h0;
        end
        else
        begin
            prev_poll <= poll_out;
            prev_kick <= watchdog_kick_in;
            since_rise <= rise ? 32'h1 : since_rise + 32'h1;
            armed <= reset_out_n && (armed || rise);
            kicked <= !rise && (kicked || (armed && prev_kick && !watchdog_kick_in));
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_idle; !reset_out_n |-> !poll_out; endproperty
    property p_period; rise && armed |-> since_rise == P; endproperty
    property p_half; $fell(poll_out) && armed && !kicked |-> since_rise == H; endproperty
    property p_kick; $fell(watchdog_kick_in) && poll_out && armed |-> ##[1:6] !poll_out; endproperty
    property p_low; armed && !poll_out && since_rise != P - 1 |=> !poll_out; endproperty
    property p_miss; armed && since_rise == P && !kicked |-> ##[0:6] !reset_out_n; endproperty
    property p_kept; armed && since_rise == P && kicked |-> reset_out_n[*4]; endproperty
    property p_drop; $fell(supply_good_in) |-> ##[1:6] (!reset_out_n && !poll_out); endproperty
    property p_rel; $rose(supply_good_in) |-> ##[RL_LO:RL_HI] $rose(reset_out_n); endproperty
    property p_pulse;
        $fell(reset_out_n) && supply_good_in |-> ##[PW_LO:PW_HI] $rose(reset_out_n);
    endproperty
    property p_lead; $rose(reset_out_n) |-> ##[LD_LO:LD_HI] $rose(poll_out); endproperty
    a_idle: assert property (p_idle) else $error("poll high in reset");
    a_period: assert property (p_period) else $error("poll period wrong");
    a_half: assert property (p_half) else $error("high phase wrong");
    a_kick: assert property (p_kick) else $error("kick not answered");
    a_low: assert property (p_low) else $error("poll rose mid cycle");
    a_miss: assert property (p_miss) else $error("missed kick no reset");
    a_kept: assert property (p_kept) else $error("reset despite kick");
    a_drop: assert property (p_drop) else $error("fault not seen");
    a_rel: assert property (p_rel) else $error("release delay wrong");
    a_pulse: assert property (p_pulse) else $error("reset width wrong");
    a_lead: assert property (p_lead) else $error("lead delay wrong");
    c_miss: cover property (armed && since_rise == P && !kicked);
    c_drop: cover property ($fell(supply_good_in));
    c_kick: cover property ($fell(watchdog_kick_in) && poll_out && armed);
endmodule
bind sleep_poll_watchdog_reset sleep_poll_watchdog_reset_properties #(
    .poll_cycles(poll_cycles), .reset_cycles(reset_cycles), .lead_cycles(lead_cycles)
) u_props (.mclk(mclk), .reset_n(reset_n), .watchdog_kick_in(watchdog_kick_in),
    .supply_good_in(supply_good_in), .poll_out(poll_out), .reset_out_n(reset_out_n));
`default_nettype wire

// >>> verif/sleep_poll_watchdog_reset_tb.sv
/* self-checking bench: power up, kicked cycles, missed kick, supply fault.
   assumes short counts set through the design parameters. */
`timescale 1ns/1ps
`default_nettype none
module sleep_poll_watchdog_reset_tb;
    localparam int P = 1200;
    localparam int R = 150;
    localparam int L = 600;
    logic mclk, reset_n, supply_good_in, host_en, twice;
    logic [7:0] delay;
    wire logic watchdog_kick_in, poll_out, reset_out_n;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'h680f;
    int n, m, d;
    sleep_poll_watchdog_reset #(.poll_cycles(P), .reset_cycles(R), .lead_cycles(L)) DUT (
        .mclk(mclk), .reset_n(reset_n), .watchdog_kick_in(watchdog_kick_in),
        .supply_good_in(supply_good_in), .poll_out(poll_out), .reset_out_n(reset_out_n));
    wakeup_host u_host (.mclk(mclk), .poll_out(poll_out), .enable(host_en), .twice(twice),
        .delay(delay), .watchdog_kick_in(watchdog_kick_in));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // poll falls a few synchroniser cycles after the kick pin
    function automatic int resp(input int k);
        return k + 4;
    endfunction
    task automatic chk(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // bounded wait for an output level; a timeout ends the run
    task automatic wait_for(input bit sel, input logic val, input int lim, output int c);
        c = 0;
        #1;
        while (c < lim && (sel ? poll_out : reset_out_n) !== val)
        begin
            @(posedge mclk);
            #1;
            c++;
        end
        if (c >= lim)
        begin
            chk("wait bound", 0, lim - 1, c);
            tally_and_finish();
        end
    endtask
    initial
    begin
        reset_n = 1'b0;
        supply_good_in = 1'b0;
        host_en = 1'b0;
        twice = 1'b1;
        delay = 8'h14;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (30) @(posedge mclk);
        #1;
        chk_bit("reset at power up", 1'b0, reset_out_n);
        chk_bit("poll at power up", 1'b0, poll_out);
        @(posedge mclk);
        supply_good_in <= 1'b1;
        host_en <= 1'b1;
        wait_for(0, 1'b1, R + 20, n);
        chk("release delay", R + 2, R + 8, n);
        wait_for(1, 1'b1, L + 20, n);
        chk("lead delay", L - 1, L + 3, n);
        // kicked cycles with random kick timing, single or double
        for (int i = 0; i < 6; i++)
        begin
            d = delay;
            delay <= 8'(10 + ($unsigned($random(seed)) % 140));
            twice <= 1'($random(seed));
            wait_for(1, 1'b0, P, n);
            chk("kick response", resp(d) - 2, resp(d) + 3, n);
            wait_for(1, 1'b1, P + 20, m);
            chk("poll period", P, P, n + m);
        end
        // last kicked cycle, then a silent one that must show its full high half
        host_en <= 1'b0;
        wait_for(1, 1'b0, P, n);
        wait_for(1, 1'b1, P + 20, m);
        chk("last kicked period", P, P, n + m);
        wait_for(1, 1'b0, P, n);
        chk("high phase", P / 2, P / 2, n);
        wait_for(0, 1'b0, P + 20, m);
        chk("missed kick reset", P - 2, P + 6, n + m);
        wait_for(0, 1'b1, R + 20, n);
        chk("reset pulse width", R - 1, R + 3, n);
        host_en <= 1'b1;
        wait_for(1, 1'b1, L + 20, n);
        chk("restart lead", L - 1, L + 3, n);
        repeat (100 + ($unsigned($random(seed)) % 300)) @(posedge mclk);
        supply_good_in <= 1'b0;
        wait_for(0, 1'b0, 8, n);
        chk("fault reset", 2, 6, n);
        chk_bit("poll in fault", 1'b0, poll_out);
        repeat (300) @(posedge mclk);
        #1;
        chk_bit("reset through fault", 1'b0, reset_out_n);
        @(posedge mclk);
        supply_good_in <= 1'b1;
        wait_for(0, 1'b1, R + 20, n);
        chk("fault release", R + 2, R + 8, n);
        wait_for(1, 1'b1, L + 20, n);
        chk("lead after fault", L - 1, L + 3, n);
        d = delay;
        wait_for(1, 1'b0, P, n);
        chk("kick after fault", resp(d) - 2, resp(d) + 3, n);
        wait_for(1, 1'b1, P + 20, m);
        chk("period after fault", P, P, n + m);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> verif/wakeup_host.sv
/* behavioural host: answers each poll rise with one or two kicks.
   assumes poll period leaves room for the pulses it is asked for. */
`timescale 1ns/1ps
`default_nettype none
module wakeup_host (
    input wire logic mclk, // system clock
    input wire logic poll_out, // poll from the supervisor
    input wire logic enable, // answer polls when high
    input wire logic twice, // second kick in the same cycle
    input wire logic [7:0] delay, // cycles from poll rise to kick
    output logic watchdog_kick_in // kick pin, idle high
);
    // kick per poll rise, phases held 250 cycles
    initial
    begin
        watchdog_kick_in = 1'b1;
        forever
        begin
            @(posedge poll_out);
            if (enable === 1'b1)
            begin
                repeat (delay) @(posedge mclk);
                watchdog_kick_in <= 1'b0;
                repeat (250) @(posedge mclk);
                watchdog_kick_in <= 1'b1;
                if (twice === 1'b1)
                begin
                    repeat (250) @(posedge mclk);
                    watchdog_kick_in <= 1'b0;
                    repeat (250) @(posedge mclk);
                    watchdog_kick_in <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire
